// [adc_frame_pkg.sv]
package adc_frame_pkg;

    // result and frame layout
    localparam int RESULT_W    = 8;
    localparam int FRAME_BITS  = 16;
    localparam int LEAD_ZEROS  = 4;
    localparam int TRAIL_ZEROS = 4;
    localparam int CNT_W       = 5;

    // edge numbers within a frame
    localparam logic [4:0] TRACK_RISE      = 5'h0d;
    localparam logic [4:0] SHDN_FIRST_FALL = 5'h02;
    localparam logic [4:0] NORMAL_FALL     = 5'h0a;
    localparam logic [4:0] LAST_FALL       = 5'h10;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int ACQ_TIME_NS   = 350;
    localparam int QUIET_TIME_NS = 50;
    localparam int TMR_W         = 7;
    localparam logic [6:0] ACQ_CYC =
        7'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] QUIET_CYC =
        7'((QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // buffering
    localparam int FIFO_DEPTH = 16;

    typedef enum {IDLE, ACTIVE} frame_state_t;

    typedef struct packed {
        logic track;
        logic shutdown;
        logic frame_done;
        logic acq_fault;
        logic quiet_fault;
    } conv_status_t;

endpackage

// [host_model.sv]
`timescale 1ns/1ps
module host_model #(
    parameter int HALF = 6
) (
    // clock
    input  wire logic clk,
    // serial pins of the converter
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe,
    input  wire logic track,
    output logic      sel_n,
    output logic      sclk
);
    logic        last_bit;
    logic        line;
    logic [15:0] word;
    logic        trk_pre;
    logic        trk_post;
    logic        oe_end;

    // a released line shows a changing level, never the last bit
    assign line = serial_result_oe ? serial_result_out : ~last_bit;

    initial begin
        last_bit = 1'b0;
        sel_n    = 1'b1;
        sclk     = 1'b0;
    end

    always @(posedge clk) begin
        last_bit <= line;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // clock idles low between frames; gap below the quiet time is a scenario's choice
    task automatic frame(input int nfall, input int gap);
        word  = 16'h0000;
        sel_n = 1'b0;
        for (int i = 0; i < nfall; i++) begin // up to sixteen cycles
            wait_cyc(HALF);
            if (i == 12) trk_pre = track;
            sclk = 1'b1;
            word = {word[14:0], line}; // capture on rise, extra zero kept
            wait_cyc(HALF);
            if (i == 12) trk_post = track;
            sclk = 1'b0;
        end
        wait_cyc(HALF);
        oe_end = serial_result_oe;
        sel_n  = 1'b1;
        wait_cyc(gap); // acquisition and quiet spacing
    endtask
endmodule

// [sample_fifo.sv]
`timescale 1ns/1ps
module sample_fifo
    import adc_frame_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;

    wire do_wr = ce & in_valid & in_ready;
    wire do_rd = ce & out_valid & out_ready;

    assign in_ready  = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// [serial_adc_readout_frame.sv]
`timescale 1ns/1ps
module serial_adc_readout_frame
    import adc_frame_pkg::*;
(
    // clock and control
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                ce,
    // serial pins from the host
    input  wire logic                sel_n_pin,
    input  wire logic                sclk_pin,
    output logic                     serial_result_out,
    output logic                     serial_result_oe,
    // digitised samples from the converter core
    input  wire logic                sample_valid,
    output logic                     sample_ready,
    input  wire logic [RESULT_W-1:0] sample_data,
    // mode and timing status
    output conv_status_t             status,
    output logic                     acquisition_window
);
    logic sel_meta, sel_s, sel_d;
    logic sclk_meta, sclk_s, sclk_d;
    frame_state_t state;
    logic [CNT_W-1:0]      fall_cnt;
    logic [CNT_W-1:0]      rise_cnt;
    logic [FRAME_BITS-1:0] shreg;
    logic [RESULT_W-1:0]   result;
    logic [TMR_W-1:0]      since_track;
    logic [TMR_W-1:0]      since_end;
    logic                  head_valid;
    logic [RESULT_W-1:0]   head_data;

    // three-stage capture of the asynchronous pins
    always_ff @(posedge clk) begin
        if (srst) begin
            {sel_meta, sel_s, sel_d}    <= 3'h7;
            {sclk_meta, sclk_s, sclk_d} <= 3'h0;
        end else if (ce) begin
            {sel_meta, sel_s, sel_d}    <= {sel_n_pin, sel_meta, sel_s};
            {sclk_meta, sclk_s, sclk_d} <= {sclk_pin, sclk_meta, sclk_s};
        end
    end

    wire sel_fall  = sel_d & ~sel_s;
    wire sel_rise  = ~sel_d & sel_s;
    wire sclk_rise = ~sclk_d & sclk_s;
    wire sclk_fall = sclk_d & ~sclk_s;

    wire start      = ce & sel_fall;
    wire active     = (state == ACTIVE);
    wire abort      = ce & active & sel_rise;
    wire next_fall  = ce & active & sclk_fall & ~sel_rise;
    wire next_rise  = ce & active & sclk_rise & ~sel_rise;
    wire fall_16    = next_fall & (fall_cnt == LAST_FALL - 5'h01);
    wire rise_13    = next_rise & (rise_cnt == TRACK_RISE - 5'h01);
    wire early_stop = (fall_cnt >= SHDN_FIRST_FALL) & (fall_cnt < NORMAL_FALL);

    wire [RESULT_W-1:0] next_sample = head_valid ? head_data : result;

    sample_fifo #(
        .W (RESULT_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (head_valid),
        .out_ready (start),
        .out_data  (head_data)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= IDLE;
        end else if (start) begin
            state <= ACTIVE;
        end else if (abort || fall_16) begin
            state <= IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fall_cnt <= '0;
            rise_cnt <= '0;
        end else if (start) begin
            fall_cnt <= '0;
            rise_cnt <= '0;
        end else begin
            if (next_fall) begin
                fall_cnt <= fall_cnt + 1'b1;
            end
            if (next_rise) begin
                rise_cnt <= rise_cnt + 1'b1;
            end
        end
    end

    // frame word: zeros, straight-binary result MSB first, zeros
    always_ff @(posedge clk) begin
        if (srst) begin
            shreg  <= '0;
            result <= '0;
        end else if (start) begin
            shreg  <= {LEAD_ZEROS'(0), next_sample, TRAIL_ZEROS'(0)};
            result <= next_sample;
        end else if (next_fall) begin
            shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
        end
    end

    assign serial_result_out = shreg[FRAME_BITS-1];

    always_ff @(posedge clk) begin
        if (srst) begin
            serial_result_oe <= 1'b0;
        end else if (start) begin
            serial_result_oe <= 1'b1;
        end else if (abort || fall_16) begin
            serial_result_oe <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status.track <= 1'b1;
        end else if (start) begin
            status.track <= 1'b0;
        end else if (rise_13 || abort) begin
            status.track <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status.shutdown <= 1'b0;
        end else if (abort && early_stop) begin
            status.shutdown <= 1'b1;
        end else if (next_fall && fall_cnt == NORMAL_FALL - 5'h01) begin
            status.shutdown <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status.frame_done <= 1'b0;
        end else if (ce) begin
            status.frame_done <= fall_16;
        end
    end

    // host timing monitors, sampled at each frame start
    always_ff @(posedge clk) begin
        if (srst) begin
            since_track <= ACQ_CYC;
            since_end   <= QUIET_CYC;
        end else if (ce) begin
            if (rise_13 || abort) begin
                since_track <= '0;
            end else if (since_track != ACQ_CYC) begin
                since_track <= since_track + 1'b1;
            end
            if (fall_16 || abort) begin
                since_end <= '0;
            end else if (since_end != QUIET_CYC) begin
                since_end <= since_end + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status.acq_fault   <= 1'b0;
            status.quiet_fault <= 1'b0;
        end else if (start) begin
            status.acq_fault   <= (since_track < ACQ_CYC);
            status.quiet_fault <= (since_end < QUIET_CYC);
        end
    end

    assign acquisition_window = status.track;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_start_drives_out:  assert property (start |=> serial_result_oe ##0 !status.track)
        else $error("frame start did not drive output and hold");
    a_track_at_13:       assert property (rise_13 |=> status.track)
        else $error("no return to track on 13th rise");
    a_hold_before_13:    assert property (active && rise_cnt < TRACK_RISE && !abort && !start
                                          && $past(start) |-> !status.track)
        else $error("track resumed early");
    a_release_at_16:     assert property (fall_16 |=> !serial_result_oe && status.frame_done)
        else $error("output not released after 16th fall");
    a_release_on_rise:   assert property (abort |=> !serial_result_oe)
        else $error("output not released on select rise");
    a_lead_zeros:        assert property (serial_result_oe && fall_cnt < 5'h04
                                          |-> !serial_result_out)
        else $error("leading bit not zero");
    a_msb_first:         assert property (serial_result_oe && fall_cnt == 5'h04
                                          |-> serial_result_out == result[RESULT_W-1])
        else $error("msb not in first data slot");
    a_trail_zeros:       assert property (serial_result_oe && fall_cnt >= 5'h0c
                                          |-> !serial_result_out)
        else $error("trailing bit not zero");
    a_change_on_fall:    assert property (!next_fall && !start |=> $stable(serial_result_out))
        else $error("output changed off a falling edge");
    a_shutdown_entry:    assert property (abort && early_stop |=> status.shutdown)
        else $error("no shutdown on early select rise");
    a_late_abort_normal: assert property (abort && fall_cnt >= NORMAL_FALL
                                          |=> !status.shutdown && !serial_result_oe)
        else $error("late abort left normal mode");
    a_acq_fault_flag:    assert property (start && since_track < ACQ_CYC |=> status.acq_fault)
        else $error("short acquisition not flagged");
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import adc_frame_pkg::*;
    logic                clk;
    logic                srst;
    logic                ce;
    logic                sel_n_pin;
    logic                sclk_pin;
    logic                serial_result_out;
    logic                serial_result_oe;
    logic                sample_valid;
    logic                sample_ready;
    logic [RESULT_W-1:0] sample_data;
    conv_status_t        status;
    logic                acquisition_window;
    int                  num_errors;
    int                  check_count;
    int                  seed;
    int                  cycles;
    int                  done_cnt;
    int                  prev_gap;
    int                  last_sample;
    int                  q[$];
    int                  nf[6] = '{1, 5, 1, 9, 12, 10};
    logic                sd[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    serial_adc_readout_frame u_serial_adc_readout_frame (
        .clk(clk), .srst(srst), .ce(ce), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
        .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .status(status),
        .acquisition_window(acquisition_window)
    );

    host_model u_host_model (
        .clk(clk), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .track(status.track),
        .sel_n(sel_n_pin), .sclk(sclk_pin)
    );

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (ce && sample_valid && sample_ready) q.push_back(int'(sample_data));
        if (status.frame_done === 1'b1) done_cnt++;
        if (cycles >= 40000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            sample_valid = 1'b1;
            sample_data  = 8'($random(seed));
            @(posedge clk);
            #1;
        end
        sample_valid = 1'b0;
    endtask

    // one frame of nfall clocks; the model pops one sample per frame start
    task automatic run(input int nfall, input int gap);
        logic [15:0] exp;
        int          n;
        if (q.size() > 0) last_sample = q.pop_front();
        exp = {4'h0, 8'(last_sample), 4'h0};
        n   = done_cnt;
        u_host_model.frame(nfall, gap);
        check("word", exp >> (16 - nfall), u_host_model.word);
        check("faults", (prev_gap < 10) ? 16'h3 : 16'h0, 16'(status[1:0]));
        check("window", 16'h1, 16'(acquisition_window));
        if (nfall == 16) begin
            check("release", 16'h0, 16'(u_host_model.oe_end));
            check("track", 16'h1, 16'({u_host_model.trk_pre, u_host_model.trk_post}));
            check("done", 16'(n + 1), 16'(done_cnt));
        end else begin
            check("held", 16'h1, 16'(u_host_model.oe_end));
            check("idle", 16'h0, 16'(serial_result_oe));
            check("no done", 16'(n), 16'(done_cnt));
        end
        prev_gap = gap;
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk          = 1'b0;
        srst         = 1'b1;
        ce           = 1'b1;
        sample_valid = 1'b0;
        sample_data  = 8'h00;
        seed         = 98;
        prev_gap     = 80;
        last_sample  = 0;
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        check("reset", 16'h0010, 16'({serial_result_oe, status}));
        fill(20);
        check("fifo level", 16'h0010, 16'(q.size()));
        check("fifo ready", 16'h0, 16'(sample_ready));
        for (int i = 0; i < 17; i++) run(16, 80);
        check("fifo drained", 16'h1, 16'(sample_ready));
        // offers made while the enable is low must not reach the buffer
        ce = 1'b0;
        fill(5);
        ce = 1'b1;
        for (int i = 0; i < 6; i++) begin
            run(nf[i], 80);
            check("shutdown", 16'(sd[i]), 16'(status.shutdown));
        end
        run(16, 3);
        run(16, 80);
        run(16, 80);
        report_and_stop();
    end
endmodule
